// ===== core/tdm_frame_pkg.sv
package tdm_frame_pkg;
   localparam int CHANNELS       = 24;
   localparam int CODE_BITS      = 8;
   localparam int FRAME_BITS     = CHANNELS * CODE_BITS + 1;
   localparam int CHAN_W         = 5;
   localparam int BIT_W          = 3;
   localparam int SIGN_POS       = 7;
   localparam int CHORD_HI       = 6;
   localparam int CHORD_LO       = 4;
   localparam int STEP_HI        = 3;
   localparam int STEP_LO        = 0;
   localparam int SEGMENTS       = 8;
   localparam int STEPS          = 16;
   localparam int MU             = 255;
   localparam int LIN_W          = 14;
   localparam int BIAS           = 33;
   localparam int SAMPLE_RATE_HZ = 8000;
   localparam int LINE_RATE_HZ   = FRAME_BITS * SAMPLE_RATE_HZ;
   localparam int FIFO_DEPTH     = 32;
   localparam int FIFO_AW        = 5;
   localparam logic [CHAN_W-1:0] CHAN_FIRST = 5'h00;
   localparam logic [CHAN_W-1:0] CHAN_LAST  = 5'h17;
   localparam logic [BIT_W-1:0]  BIT_FIRST  = 3'h7;
   localparam logic [BIT_W-1:0]  BIT_LAST   = 3'h0;
   localparam logic [CODE_BITS-1:0] IDLE_CODE = 8'hFF;
   typedef enum logic [1:0] {
      SEND_FRAMING = 2'b00,
      SEND_CODE    = 2'b01
   } send_e;
endpackage

// ===== core/sample_fifo.sv
`timescale 1ns/10ps
module sample_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   input  wire logic             clk,      // bit clock
   input  wire logic             rst,      // async reset
   input  wire logic [WIDTH-1:0] inData,   // write data
   input  wire logic             inValid,  // write valid
   output logic                  inReady,  // space available
   output logic      [WIDTH-1:0] outData,  // head word
   output logic                  outValid, // head valid
   input  wire logic             outReady  // head taken
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr;
   logic [AW-1:0]    rdPtr;
   logic [AW:0]      count;
   wire              doWrite = inValid && inReady;
   wire              doRead  = outValid && outReady;
   assign inReady  = (count != AW'(0) - 0) ? (count < (AW+1)'(DEPTH)) : 1'b1;
   assign outValid = (count != '0);
   assign outData  = mem[rdPtr];
   always_ff @(posedge clk) begin
      if (doWrite) begin
         mem[wrPtr] <= inData;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (doWrite) begin
            wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : AW'(wrPtr + 1'b1);
         end
         if (doRead) begin
            rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : AW'(rdPtr + 1'b1);
         end
         count <= (AW+1)'(count + (AW+1)'(doWrite) - (AW+1)'(doRead));
      end
   end
endmodule

// ===== core/mulaw_encoder.sv
`timescale 1ns/10ps
module mulaw_encoder
   import tdm_frame_pkg::*;
(
   input  wire logic                  sign,      // 1 = negative sample
   input  wire logic [LIN_W-1:0]      magnitude, // linear magnitude
   output logic      [CODE_BITS-1:0]  code       // companded codeword
);
   logic [LIN_W:0]     biased;
   logic [2:0]         chord;
   logic [3:0]         step;
   wire  [LIN_W:0]     clipped;
   // saturate so the top segment holds full scale
   assign clipped = ({1'b0, magnitude} + (LIN_W+1)'(BIAS) > 15'h1FFF)
                    ? 15'h1FFF : (LIN_W+1)'({1'b0, magnitude} + (LIN_W+1)'(BIAS));
   always_comb begin
      biased = clipped;
      chord  = 3'h0;
      for (int i = SEGMENTS-1; i >= 1; i--) begin
         if (biased[i+5] && chord == 3'h0) begin
            chord = 3'(i);
         end
      end
      step = biased[chord+1 +: 4];
   end
   // codes are inverted on the line, as usual for this law
   assign code = ~{sign, chord, step};
endmodule

// ===== core/pcm_tdm_frame_multiplexer.sv
`timescale 1ns/10ps
module pcm_tdm_frame_multiplexer
   import tdm_frame_pkg::*;
#(
   parameter int CH    = CHANNELS,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic             clk,          // 1.544 MHz bit clock
   input  wire logic             rst,          // async reset, active high
   input  wire logic             sampleSign,   // sample polarity
   input  wire logic [LIN_W-1:0] sampleMag,    // linear sample magnitude
   input  wire logic             sampleValid,  // sample offered
   output logic                  sampleReady,  // sample accepted
   input  wire logic             framingBit,   // framing pattern bit
   output logic                  lineData,     // serial line data
   output logic                  frameStart,   // high with framing bit
   output logic                  underrun      // slot had no sample
);
   import tdm_frame_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic [CODE_BITS-1:0] codeIn;
   logic [CODE_BITS-1:0] codeOut;
   logic                 codeValid;
   logic                 codeTake;

   mulaw_encoder u_enc (
      .sign      (sampleSign),
      .magnitude (sampleMag),
      .code      (codeIn)
   );

   // fifo decouples codec timing from line timing; ready stalls the source
   sample_fifo #(
      .WIDTH (CODE_BITS),
      .DEPTH (DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .clk      (clk),
      .rst      (rst),
      .inData   (codeIn),
      .inValid  (sampleValid),
      .inReady  (sampleReady),
      .outData  (codeOut),
      .outValid (codeValid),
      .outReady (codeTake)
   );

   ////////////////////////////////////////////////////////////////////////
   send_e                state;
   send_e                next_state;
   logic [CHAN_W-1:0]    chan;
   logic [BIT_W-1:0]     bitIdx;
   logic [CODE_BITS-1:0] shift;
   wire                  lastBit  = (bitIdx == BIT_LAST);
   wire                  lastChan = (chan == CHAN_W'(CH-1));
   wire                  loadCode = (state == SEND_FRAMING) || (lastBit && !lastChan);
   assign codeTake = loadCode && codeValid;

   always_comb begin
      next_state = state;
      unique case (state)
         SEND_FRAMING: next_state = SEND_CODE;
         SEND_CODE:    next_state = (lastBit && lastChan) ? SEND_FRAMING : SEND_CODE;
         // the two spare encodings fall back to a fresh frame
         default:      next_state = SEND_FRAMING;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state      <= SEND_FRAMING;
         chan       <= CHAN_FIRST;
         bitIdx     <= BIT_FIRST;
         shift      <= '0;
         lineData   <= 1'b0;
         frameStart <= 1'b0;
         underrun   <= 1'b0;
      end else begin
         state      <= next_state;
         frameStart <= (state == SEND_FRAMING);
         if (state == SEND_FRAMING) begin
            lineData <= framingBit;
            chan     <= CHAN_FIRST;
            bitIdx   <= BIT_FIRST;
         end else begin
            lineData <= shift[SIGN_POS];
            bitIdx   <= lastBit ? BIT_FIRST : BIT_W'(bitIdx - 1'b1);
            if (lastBit) begin
               chan <= lastChan ? CHAN_FIRST : CHAN_W'(chan + 1'b1);
            end
         end
         if (loadCode) begin
            // idle code on underrun keeps frame length fixed
            shift    <= codeValid ? codeOut : IDLE_CODE;
            underrun <= !codeValid;
         end else begin
            shift    <= {shift[CODE_BITS-2:0], 1'b0};
            underrun <= 1'b0;
         end
      end
   end
endmodule

// ===== bench/tdm_mux_props.sv
`timescale 1ns/10ps
module tdm_mux_props
   import tdm_frame_pkg::*;
#(parameter int CH = CHANNELS, parameter int DEPTH = FIFO_DEPTH) (
   input wire logic             clk,         // clock
   input wire logic             rst,         // reset
   input wire logic             sampleSign,  // sign
   input wire logic [LIN_W-1:0] sampleMag,   // magnitude
   input wire logic             sampleValid, // offered
   input wire logic             sampleReady, // accepted
   input wire logic             framingBit,  // framing
   input wire logic             lineData,    // line
   input wire logic             frameStart,  // marker
   input wire logic             underrun     // empty slot
);
   logic [8:0] gap;
   logic       seen;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gap  <= 9'h000;
         seen <= 1'b0;
      end else begin
         gap  <= frameStart ? 9'h000 : gap + 9'h001;
         seen <= seen | frameStart;
      end
   end
   a_frame_period: assert property (frameStart && seen |-> gap == 9'(CH * CODE_BITS))
      else $error("frame period wrong");
   a_period_bound: assert property (gap <= 9'(CH * CODE_BITS))
      else $error("frame marker missing");
   a_start_gap: assert property (frameStart |=> !frameStart [*8])
      else $error("marker too soon");
   a_reset_start: assert property ($fell(rst) |-> ##[1:2] frameStart)
      else $error("no framing bit after reset");
   a_reset_ready: assert property ($fell(rst) |-> sampleReady)
      else $error("not ready after reset");
   a_framing_bit: assert property (frameStart |-> lineData == $past(framingBit))
      else $error("framing bit wrong");
   a_underrun_spacing: assert property (underrun |=> !underrun [*7])
      else $error("slots closer than a codeword");
   a_underrun_ready: assert property (underrun |-> sampleReady)
      else $error("empty buffer refuses samples");
   cover property (frameStart && seen);
   cover property (underrun);
   cover property (sampleValid && !sampleReady);
endmodule

// ===== bench/line_sink.sv
`timescale 1ns/10ps
module line_sink (
   input  wire logic       clk,        // bit clock
   input  wire logic       lineData,   // serial in
   input  wire logic       frameStart, // frame marker
   output logic      [7:0] word,       // codeword
   output logic            wordValid,  // word done
   output int              frames      // frames seen
);
   logic [7:0] sh;
   int         k;
   initial frames = 0;
   always @(posedge clk) begin
      wordValid <= 1'b0;
      if (frameStart) begin
         k = 0;
         frames <= frames + 1;
      end else begin
         sh = {sh[6:0], lineData};
         k = k + 1;
         if (k == 8) begin
            word <= sh;
            wordValid <= 1'b1;
            k = 0;
         end
      end
   end
endmodule

// ===== bench/pcm_tdm_frame_multiplexer_tb.sv
`timescale 1ns/10ps
module pcm_tdm_frame_multiplexer_tb;
   import tdm_frame_pkg::*;
   logic clk = 0, rst = 1, sampleSign = 0, sampleValid = 0, framingBit = 0;
   logic [LIN_W-1:0] sampleMag = '0;
   logic sampleReady, lineData, frameStart, underrun, wordValid;
   logic [7:0] word, exp[$];
   int frames, fc = 0, pushed = 0, mismatches = 0, comparisons = 0;
   logic sawUnderrun = 0;
   always #5 clk = ~clk;
   pcm_tdm_frame_multiplexer u_dut (.clk(clk), .rst(rst), .sampleSign(sampleSign),
      .sampleMag(sampleMag), .sampleValid(sampleValid), .sampleReady(sampleReady),
      .framingBit(framingBit), .lineData(lineData), .frameStart(frameStart),
      .underrun(underrun));
   line_sink u_sink (.clk(clk), .lineData(lineData), .frameStart(frameStart),
      .word(word), .wordValid(wordValid), .frames(frames));
   ////////////////////////////////////////////////////////////////
   function automatic logic [7:0] enc(logic s, logic [LIN_W-1:0] m);
      logic [LIN_W-1:0] b;
      int c;
      b = m + 14'h0021;
      c = 7;
      while (c > 0 && !b[c+5]) c--;
      return ~{s, 3'(c), b[c+1 +: 4]};
   endfunction
   task automatic check(logic [7:0] got, logic [7:0] want);
      comparisons++;
      if (got !== want) begin
         mismatches++;
         $display("[FAIL] %0t got %h want %h", $time, got, want);
      end
   endtask
   task final_report;
      $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // framing bit moves only mid-frame, so its exact sampling cycle does not matter
   always @(posedge clk) begin
      fc <= frameStart ? 0 : fc + 1;
      if (fc == 96) framingBit <= 1'($urandom);
      if (!rst && sampleValid && sampleReady) begin
         exp.push_back(enc(sampleSign, sampleMag));
         pushed++;
      end
   end
   // the first frame loads all its slots before any sample is queued and is all fill
   always @(posedge clk) begin
      if (underrun) sawUnderrun <= 1'b1;
      if (frameStart) check({7'h00, lineData}, {7'h00, framingBit});
      if (wordValid && frames > 1 && exp.size() > 0) check(word, exp.pop_front());
   end
   initial begin
      void'($urandom(32'hE4E83FBA));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      while (frames < 1) @(posedge clk);
      // start early enough that channel 0 of the second frame finds a sample
      repeat (182) @(posedge clk);
      while (pushed < 150) begin
         @(posedge clk);
         sampleValid <= ($urandom % 4) != 0;
         sampleSign  <= 1'($urandom);
         sampleMag   <= (pushed % 16 == 0) ? '0 : LIN_W'($urandom % 7001);
      end
      @(posedge clk);
      sampleValid <= 1'b0;
      for (int i = 0; i < 600 && exp.size() > 0; i++) @(posedge clk);
      if (exp.size() > 0) begin
         mismatches++;
         $display("[FAIL] %0t words never sent", $time);
      end
      sawUnderrun <= 1'b0;
      repeat (20) @(posedge clk);
      check({7'h00, sawUnderrun}, 8'h01);
      final_report;
   end
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      $display("[FAIL] %0t watchdog expired", $time);
      final_report;
   end
endmodule
bind pcm_tdm_frame_multiplexer tdm_mux_props #(.CH(CH), .DEPTH(DEPTH)) u_props (.clk(clk),
   .rst(rst), .sampleSign(sampleSign), .sampleMag(sampleMag), .sampleValid(sampleValid),
   .sampleReady(sampleReady), .framingBit(framingBit), .lineData(lineData),
   .frameStart(frameStart), .underrun(underrun));
